// ---- verilog/usr_pkg.sv ----
// Overview of operation
// - device status bit D4 reports whether latency tolerance messages are enabled.
// - LTM enable changes only by set/clear feature LTM; zero after reset.
// - first interface status bit D0 shows function remote wake capability.
// - first interface bit D1 shows wake enable; zero by default and function reset.
// - wake enable changes only by set feature function suspend, or clears by function reset.
// - status of any other interface returns two zero bytes.
// - unused interface and endpoint status bits up to D15 read zero.
// - every bulk and interrupt endpoint keeps a halt bit read back in status.
// - halt set by request stalls exactly like a hardware halt.
// - clear halt request ends stalling only if the halting condition is already gone.
// - every clear halt resets data sequence, and stream state when streams enabled.
// - halt bits clear after any successful set configuration or set interface.
// - set address with type zero takes the value field as new address.
// - new address is adopted only after a successful status stage.
// - other requests finish their operation before the status stage.
// - default state: nonzero address enters address state, zero stays default.
// - address state: zero address returns to default, nonzero keeps address state.
// - set configuration uses value low byte; zero means address state.
// - address state: zero stays, match configures, other value is request error.
// - configured state: zero to address, match stays configured, other is error.
package usr_pkg;
  localparam int NUM_EP = 4;
  localparam int NUM_IF = 2;
  typedef enum logic [2:0] {
    DEV_DEFAULT = 3'h1,
    DEV_ADDRESS = 3'h2,
    DEV_CONFIGURED = 3'h4
  } usr_dev_t;
  localparam logic [7:0] REQ_GET_STATUS = 8'h00;
  localparam logic [7:0] REQ_CLR_FEATURE = 8'h01;
  localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
  localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
  localparam logic [7:0] REQ_SET_CONFIG = 8'h09;
  localparam logic [7:0] REQ_SET_IFACE = 8'h0B;
  localparam logic [7:0] TYPE_STD_DEV_OUT = 8'h00;
  localparam logic [4:0] RCP_DEV = 5'h00;
  localparam logic [4:0] RCP_IF = 5'h01;
  localparam logic [4:0] RCP_EP = 5'h02;
  localparam logic [15:0] FEAT_EP_HALT = 16'h0000;
  localparam logic [15:0] FEAT_FUNC_SUSP = 16'h0000;
  localparam logic [15:0] FEAT_LTM = 16'h0032;
  localparam int DEV_LTM_BIT = 4;
  localparam int IF_CAP_BIT = 0;
  localparam int IF_WAKE_BIT = 1;
  localparam int SUSP_WAKE_BIT = 9;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HALT = 8'h08;
  localparam logic [7:0] CFG_VALUE_RST = 8'h01;
  localparam int CTRL_CAP_BIT = 8;
  localparam int CTRL_STREAM_BIT = 9;
  localparam int ST_ADDR_LSB = 0;
  localparam int ST_STATE_LSB = 8;
  localparam int ST_LTM_BIT = 11;
  localparam int ST_WAKE_BIT = 12;
  localparam int ST_CFG_LSB = 16;
endpackage

// ---- verilog/usr_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface usr_link_if;
  import usr_pkg::*;
  logic [NUM_EP-1:0] haltSet;
  logic [NUM_EP-1:0] haltClr;
  logic haltAll;
  logic [NUM_EP-1:0] halted;
  logic [NUM_EP-1:0] seqRst;
  logic [NUM_EP-1:0] streamRst;
  logic [7:0] cfgValue;
  logic wakeCap;
  logic streamEn;
  logic [31:0] statusWord;
  modport core (output haltSet, haltClr, haltAll, statusWord, input halted, cfgValue, wakeCap);
  modport bank (input haltSet, haltClr, haltAll, streamEn, output halted, seqRst, streamRst);
  modport regs (output cfgValue, wakeCap, streamEn, input statusWord, halted);
endinterface
`default_nettype wire

// ---- verilog/usr_ep_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module usr_ep_bank
  import usr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // hardware halt causes
  input wire logic [NUM_EP-1:0] epHaltCond,
  // core side
  usr_link_if.bank lnk
);
  typedef struct packed {
    logic [NUM_EP-1:0] halted;
    logic [NUM_EP-1:0] seqRst;
    logic [NUM_EP-1:0] streamRst;
  } usr_bank_t;
  usr_bank_t q, d;
  logic [NUM_EP-1:0] haltNext;

  // a live hardware cause wins over any clear
  for (genvar i = 0; i < NUM_EP; i++)
  begin : g_ep
    assign haltNext[i] = (q.halted[i] & ~lnk.haltClr[i] & ~lnk.haltAll) | lnk.haltSet[i] | epHaltCond[i];
  end

  always_comb
  begin
    d = q;
    d.halted = haltNext;
    d.seqRst = lnk.haltClr;
    d.streamRst = lnk.streamEn ? lnk.haltClr : '0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign lnk.halted = q.halted;
  assign lnk.seqRst = q.seqRst;
  assign lnk.streamRst = q.streamRst;

  AST_HALT_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
    (lnk.haltClr[0] && !lnk.haltSet[0] && !epHaltCond[0]) |=> !q.halted[0])
    else $error("halt bit stays after clear without cause");
  AST_SEQ_RESET: assert property (@(posedge mclk) disable iff (sys_rst)
    (lnk.haltClr != '0) |=> (q.seqRst == $past(lnk.haltClr)) ##1 (q.seqRst == $past(lnk.haltClr)))
    else $error("sequence reset does not follow clear halt");
endmodule
`default_nettype wire

// ---- verilog/usr_reg_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module usr_reg_port
  import usr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // core side
  usr_link_if.regs lnk
);
  typedef struct packed {
    logic [7:0] cfgValue;
    logic wakeCap;
    logic streamEn;
    logic [31:0] rdata;
  } usr_regs_t;
  usr_regs_t q, d;

  always_comb
  begin
    d = q;
    d.rdata = '0;
    if (regWr && regAddr == REG_CTRL)
    begin
      d.cfgValue = regWdata[7:0];
      d.wakeCap = regWdata[CTRL_CAP_BIT];
      d.streamEn = regWdata[CTRL_STREAM_BIT];
    end
    // unmapped reads answer zero
    if (regRd)
    begin
      case (regAddr)
        REG_CTRL:
        begin
          d.rdata[7:0] = q.cfgValue;
          d.rdata[CTRL_CAP_BIT] = q.wakeCap;
          d.rdata[CTRL_STREAM_BIT] = q.streamEn;
        end
        REG_STATUS: d.rdata = lnk.statusWord;
        REG_HALT: d.rdata[NUM_EP-1:0] = lnk.halted;
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '{cfgValue: CFG_VALUE_RST, wakeCap: 1'b0, streamEn: 1'b0, rdata: 32'h0000_0000};
    else
      q <= d;
  end

  assign regRdata = q.rdata;
  assign lnk.cfgValue = q.cfgValue;
  assign lnk.wakeCap = q.wakeCap;
  assign lnk.streamEn = q.streamEn;
endmodule
`default_nettype wire

// ---- verilog/usr_std_req.sv ----
`timescale 1ns/1ps
`default_nettype none
module usr_std_req
  import usr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // decoded setup packet
  input wire logic reqValid,
  input wire logic [7:0] reqType,
  input wire logic [7:0] reqCode,
  input wire logic [15:0] reqValue,
  input wire logic [15:0] reqIndex,
  input wire logic [15:0] reqLength,
  // request answer
  output logic reqDone,
  output logic reqErr,
  output logic [15:0] replyData,
  // status stage
  input wire logic statusOk,
  // function reset
  input wire logic funcRst,
  // endpoints
  input wire logic [NUM_EP-1:0] epHaltCond,
  output logic [NUM_EP-1:0] epStall,
  output logic [NUM_EP-1:0] epSeqRst,
  output logic [NUM_EP-1:0] epStreamRst,
  // device state
  output logic [2:0] devState,
  output logic [6:0] devAddr,
  output logic ltmEnable,
  output logic funcWakeEn,
  output logic [7:0] activeCfg,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    usr_dev_t state;
    logic [6:0] addr;
    logic [6:0] pendAddr;
    logic pendValid;
    logic ltm;
    logic fwake;
    logic [7:0] cfg;
    logic done;
    logic err;
    logic [15:0] reply;
    logic [NUM_EP-1:0] haltSet;
    logic [NUM_EP-1:0] haltClr;
    logic haltAll;
  } usr_core_t;
  usr_core_t q, d;
  usr_link_if lnk();

  // endpoint number in index low bits, direction bit ignored
  function automatic logic [NUM_EP-1:0] epOneHot(input logic [15:0] idx);
    epOneHot = '0;
    for (int i = 0; i < NUM_EP; i++)
    begin
      if (idx[3:0] == 4'(i + 1))
        epOneHot[i] = 1'b1;
    end
  endfunction

  logic [4:0] rcp;
  logic [NUM_EP-1:0] epHit;
  logic epZero;
  logic isCfg;
  logic ifOk;
  assign rcp = reqType[4:0];
  assign epHit = epOneHot(reqIndex);
  assign epZero = reqIndex[3:0] == 4'h0;
  assign isCfg = q.state == DEV_CONFIGURED;
  assign ifOk = isCfg && reqIndex[7:0] < 8'(NUM_IF);

  // ----------------------------------------
  // request handling
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.err = 1'b0;
    d.haltSet = '0;
    d.haltClr = '0;
    d.haltAll = 1'b0;
    // address moves only once the status stage is through
    if (statusOk && q.pendValid)
    begin
      d.pendValid = 1'b0;
      d.addr = q.pendAddr;
      d.state = (q.pendAddr == 7'h00) ? DEV_DEFAULT : DEV_ADDRESS;
    end
    if (funcRst)
      d.fwake = 1'b0;
    if (reqValid)
    begin
      // effects other than set address land with the answer (halt bits a cycle later), ahead of any status stage
      d.done = 1'b1;
      d.reply = '0;
      case (reqCode)
        REQ_GET_STATUS:
        begin
          if (rcp == RCP_DEV)
            d.reply[DEV_LTM_BIT] = q.ltm;
          else if (rcp == RCP_IF && ifOk)
          begin
            if (reqIndex[7:0] == 8'h00)
            begin
              d.reply[IF_CAP_BIT] = lnk.wakeCap;
              d.reply[IF_WAKE_BIT] = q.fwake;
            end
          end
          else if (rcp == RCP_EP && epZero)
            d.reply = '0;
          else if (rcp == RCP_EP && isCfg && epHit != '0)
            d.reply[0] = |(epHit & lnk.halted);
          else
            d.err = 1'b1;
        end
        REQ_CLR_FEATURE:
        begin
          if (rcp == RCP_DEV && reqValue == FEAT_LTM)
            d.ltm = 1'b0;
          else if (rcp == RCP_EP && reqValue == FEAT_EP_HALT && epZero)
            d.err = 1'b0;
          else if (rcp == RCP_EP && reqValue == FEAT_EP_HALT && isCfg && epHit != '0)
            d.haltClr = epHit;
          else
            d.err = 1'b1;
        end
        REQ_SET_FEATURE:
        begin
          if (rcp == RCP_DEV && reqValue == FEAT_LTM && isCfg)
            d.ltm = 1'b1;
          else if (rcp == RCP_IF && reqValue == FEAT_FUNC_SUSP && isCfg && reqIndex[7:0] == 8'h00)
            d.fwake = reqIndex[SUSP_WAKE_BIT];
          else if (rcp == RCP_EP && reqValue == FEAT_EP_HALT && isCfg && epHit != '0)
            d.haltSet = epHit;
          else
            d.err = 1'b1;
        end
        REQ_SET_ADDRESS:
        begin
          // values above 127 are the host's problem; only seven bits kept
          if (reqType == TYPE_STD_DEV_OUT)
          begin
            d.pendAddr = reqValue[6:0];
            d.pendValid = 1'b1;
          end
          else
            d.err = 1'b1;
        end
        REQ_SET_CONFIG:
        begin
          // high value byte, index and length assumed zero by the host
          if (q.state == DEV_DEFAULT)
            d.err = 1'b1;
          else if (reqValue[7:0] == 8'h00)
          begin
            d.state = DEV_ADDRESS;
            d.cfg = 8'h00;
            d.haltAll = 1'b1;
          end
          else if (reqValue[7:0] == lnk.cfgValue)
          begin
            d.state = DEV_CONFIGURED;
            d.cfg = reqValue[7:0];
            d.haltAll = 1'b1;
          end
          else
            d.err = 1'b1;
        end
        REQ_SET_IFACE:
        begin
          // only alternate setting zero exists
          if (ifOk && reqValue == 16'h0000 && reqLength == 16'h0000)
            d.haltAll = 1'b1;
          else
            d.err = 1'b1;
        end
        default: d.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '{state: DEV_DEFAULT, addr: 7'h00, pendAddr: 7'h00, pendValid: 1'b0, ltm: 1'b0, fwake: 1'b0,
             cfg: 8'h00, done: 1'b0, err: 1'b0, reply: 16'h0000, haltSet: '0, haltClr: '0, haltAll: 1'b0};
    else
      q <= d;
  end

  // ----------------------------------------
  // submodules and outputs
  // ----------------------------------------
  always_comb
  begin
    lnk.statusWord = '0;
    lnk.statusWord[ST_ADDR_LSB +: 7] = q.addr;
    lnk.statusWord[ST_STATE_LSB +: 3] = q.state;
    lnk.statusWord[ST_LTM_BIT] = q.ltm;
    lnk.statusWord[ST_WAKE_BIT] = q.fwake;
    lnk.statusWord[ST_CFG_LSB +: 8] = q.cfg;
  end
  assign lnk.haltSet = q.haltSet;
  assign lnk.haltClr = q.haltClr;
  assign lnk.haltAll = q.haltAll;

  usr_ep_bank u_bank (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .epHaltCond(epHaltCond),
    .lnk(lnk.bank)
  );

  usr_reg_port u_regs (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .lnk(lnk.regs)
  );

  assign reqDone = q.done;
  assign reqErr = q.err;
  assign replyData = q.reply;
  assign epStall = lnk.halted;
  assign epSeqRst = lnk.seqRst;
  assign epStreamRst = lnk.streamRst;
  assign devState = q.state;
  assign devAddr = q.addr;
  assign ltmEnable = q.ltm;
  assign funcWakeEn = q.fwake;
  assign activeCfg = q.cfg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence sAddrReq;
    reqValid && reqCode == REQ_SET_ADDRESS && reqType == TYPE_STD_DEV_OUT;
  endsequence
  sequence sAddrCommit;
    sAddrReq ##1 (!reqValid && !statusOk) ##1 (statusOk && !reqValid);
  endsequence
  sequence sCfgOk;
    reqValid && reqCode == REQ_SET_CONFIG ##1 (reqDone && !reqErr);
  endsequence

  AST_LTM_REPLY: assert property (@(posedge mclk) disable iff (sys_rst)
    (reqValid && reqCode == REQ_GET_STATUS && rcp == RCP_DEV) |=> (replyData[DEV_LTM_BIT] == ltmEnable))
    else $error("device status bit D4 differs from LTM enable");
  AST_LTM_SOURCE: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(ltmEnable) |-> $past(reqValid && reqValue == FEAT_LTM
      && (reqCode == REQ_SET_FEATURE || reqCode == REQ_CLR_FEATURE)))
    else $error("LTM enable changed without feature request");
  AST_IF_FIRST: assert property (@(posedge mclk) disable iff (sys_rst)
    (reqValid && reqCode == REQ_GET_STATUS && rcp == RCP_IF && isCfg && reqIndex[7:0] == 8'h00)
      |=> (!reqErr && replyData[IF_CAP_BIT] == $past(lnk.wakeCap) && replyData[IF_WAKE_BIT] == $past(q.fwake)))
    else $error("first interface status word wrong");
  AST_FWAKE_RST: assert property (@(posedge mclk) disable iff (sys_rst)
    (funcRst && !(reqValid && reqCode == REQ_SET_FEATURE)) |=> !funcWakeEn)
    else $error("function reset left wake enable set");
  AST_FWAKE_SOURCE: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(funcWakeEn) |-> $past(reqValid && reqCode == REQ_SET_FEATURE && rcp == RCP_IF))
    else $error("wake enable set without function suspend request");
  AST_IF_OTHER: assert property (@(posedge mclk) disable iff (sys_rst)
    (reqValid && reqCode == REQ_GET_STATUS && rcp == RCP_IF && reqIndex[7:0] != 8'h00) |=> (replyData == 16'h0000))
    else $error("other interface status not zero");
  AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(reqValid && reqCode == REQ_GET_STATUS && rcp != RCP_DEV) |-> (replyData[15:2] == 14'h0000))
    else $error("reserved status bits not zero");
  AST_HALT_REPLY: assert property (@(posedge mclk) disable iff (sys_rst)
    (reqValid && reqCode == REQ_GET_STATUS && rcp == RCP_EP && isCfg && epHit != '0)
      |=> (replyData[0] == $past(|(epHit & epStall))))
    else $error("endpoint halt bit misreported");
  AST_HALT_STALL: assert property (@(posedge mclk) disable iff (sys_rst)
    (reqValid && reqCode == REQ_SET_FEATURE && rcp == RCP_EP && reqValue == FEAT_EP_HALT && isCfg && epHit != '0)
      |=> ##1 ((epStall & $past(epHit, 2)) == $past(epHit, 2)))
    else $error("set halt did not stall endpoint");
  AST_CFG_HALT_CLR: assert property (@(posedge mclk) disable iff (sys_rst)
    sCfgOk |=> (epStall == $past(epHaltCond)))
    else $error("halt bits survived set configuration");
  AST_ADDR_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(devAddr) |-> $past(statusOk))
    else $error("address changed without status stage");
  AST_ADDR_TAKE: assert property (@(posedge mclk) disable iff (sys_rst)
    sAddrCommit |=> (devAddr == $past(reqValue[6:0], 3)
      && devState == (($past(reqValue[6:0], 3) == 7'h00) ? DEV_DEFAULT : DEV_ADDRESS)))
    else $error("set address not adopted after status stage");
  AST_DONE_NEXT: assert property (@(posedge mclk) disable iff (sys_rst)
    reqValid |=> reqDone)
    else $error("request not answered next cycle");
  AST_CFG_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    (reqValid && reqCode == REQ_SET_CONFIG && reqValue[7:0] == 8'h00 && devState != DEV_DEFAULT)
      |=> (devState == DEV_ADDRESS && activeCfg == 8'h00 && !reqErr))
    else $error("zero configuration did not give address state");
  AST_CFG_MATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    (reqValid && reqCode == REQ_SET_CONFIG && reqValue[7:0] != 8'h00 && reqValue[7:0] == lnk.cfgValue
      && devState != DEV_DEFAULT) |=> (devState == DEV_CONFIGURED && !reqErr))
    else $error("matching configuration not entered");
  AST_CFG_BAD: assert property (@(posedge mclk) disable iff (sys_rst)
    (reqValid && reqCode == REQ_SET_CONFIG && reqValue[7:0] != 8'h00 && reqValue[7:0] != lnk.cfgValue
      && !statusOk) |=> (reqErr && $stable(devState)))
    else $error("bad configuration value not refused");
endmodule
`default_nettype wire

// ---- verification/usr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module usr_host_model
  import usr_pkg::*;
(
  // clock
  input wire logic mclk,
  // request side
  output logic reqValid,
  output logic [7:0] reqType,
  output logic [7:0] reqCode,
  output logic [15:0] reqValue,
  output logic [15:0] reqIndex,
  output logic [15:0] reqLength,
  output logic statusOk
);
  initial
  begin
    reqValid = 1'b0;
    reqType = 8'h00;
    reqCode = 8'h00;
    reqValue = 16'h0000;
    reqIndex = 16'h0000;
    reqLength = 16'h0000;
    statusOk = 1'b0;
  end
  // one setup packet; fields scrambled once released so stale values cannot help
  task automatic send(input logic [7:0] t, input logic [7:0] c, input logic [15:0] v, input logic [15:0] i);
    @(posedge mclk);
    reqType <= t;
    reqCode <= c;
    reqValue <= v;
    reqIndex <= i;
    reqLength <= 16'h0000;
    reqValid <= 1'b1;
    @(posedge mclk);
    reqValid <= 1'b0;
    reqType <= ~t;
    reqCode <= ~c;
    reqValue <= ~v;
    reqIndex <= ~i;
    reqLength <= 16'hFFFF;
  endtask
  // status stage completes successfully
  task automatic ack();
    @(posedge mclk);
    statusOk <= 1'b1;
    @(posedge mclk);
    statusOk <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/usr_std_req_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module usr_std_req_tb;
  import usr_pkg::*;
  logic mclk, sys_rst, reqValid, statusOk, funcRst, regWr, regRd, reqDone, reqErr, ltmEnable, funcWakeEn;
  logic [7:0] reqType, reqCode, regAddr, activeCfg;
  logic [15:0] reqValue, reqIndex, reqLength, replyData;
  logic [NUM_EP-1:0] epHaltCond, epStall, epSeqRst, epStreamRst;
  logic [2:0] devState;
  logic [6:0] devAddr;
  logic [31:0] regWdata, regRdata;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  usr_std_req u_dut (.mclk(mclk), .sys_rst(sys_rst), .reqValid(reqValid), .reqType(reqType), .reqCode(reqCode),
    .reqValue(reqValue), .reqIndex(reqIndex), .reqLength(reqLength), .reqDone(reqDone), .reqErr(reqErr),
    .replyData(replyData), .statusOk(statusOk), .funcRst(funcRst), .epHaltCond(epHaltCond), .epStall(epStall),
    .epSeqRst(epSeqRst), .epStreamRst(epStreamRst), .devState(devState), .devAddr(devAddr),
    .ltmEnable(ltmEnable), .funcWakeEn(funcWakeEn), .activeCfg(activeCfg), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  usr_host_model u_host (.mclk(mclk), .reqValid(reqValid), .reqType(reqType), .reqCode(reqCode),
    .reqValue(reqValue), .reqIndex(reqIndex), .reqLength(reqLength), .statusOk(statusOk));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      $display("MISMATCH %s expected %h seen %h", n, x, g);
      n_mismatch++;
    end
  endtask
  task automatic st();
    @(posedge mclk);
    #1;
  endtask
  task automatic rq(input logic [7:0] t, input logic [7:0] c, input logic [15:0] v, input logic [15:0] i,
    input logic e, input logic [15:0] r);
    u_host.send(t, c, v, i);
    #1;
    chk("reqDone", 1, reqDone);
    chk("reqErr", e, reqErr);
    chk("replyData", r, replyData);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk("regRdata", x, regRdata);
  endtask
  // address change waits for the status stage
  task automatic sa(input logic [6:0] a, input logic [6:0] old, input logic [2:0] s);
    rq(8'h00, REQ_SET_ADDRESS, {9'h000, a}, 16'h0000, 1'b0, 16'h0000);
    chk("devAddr", old, devAddr);
    u_host.ack();
    #1;
    chk("devAddr", a, devAddr);
    chk("devState", s, devState);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("devState", DEV_DEFAULT, devState);
    chk("ltmEnable", 0, ltmEnable);
    rd(REG_CTRL, 32'h0000_0001);
    rd(8'h0C, 32'h0000_0000);
  endtask
  task automatic t_addr();
    rq(8'h01, REQ_SET_ADDRESS, 16'h0005, 16'h0000, 1'b1, 16'h0000);
    sa(7'h00, 7'h00, DEV_DEFAULT);
    sa(7'h05, 7'h00, DEV_ADDRESS);
    sa(7'h00, 7'h05, DEV_DEFAULT);
    sa(7'h7F, 7'h00, DEV_ADDRESS);
    sa(7'h21, 7'h7F, DEV_ADDRESS);
    rq(8'h00, REQ_SET_FEATURE, FEAT_LTM, 16'h0000, 1'b1, 16'h0000);
    chk("ltmEnable", 0, ltmEnable);
  endtask
  task automatic t_cfg();
    wr(REG_CTRL, 32'h0000_0302);
    rq(8'h00, REQ_SET_CONFIG, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    chk("devState", DEV_ADDRESS, devState);
    rq(8'h00, REQ_SET_CONFIG, 16'h0003, 16'h0000, 1'b1, 16'h0000);
    chk("devState", DEV_ADDRESS, devState);
    rq(8'h00, REQ_SET_CONFIG, 16'h0002, 16'h0000, 1'b0, 16'h0000);
    chk("devState", DEV_CONFIGURED, devState);
    chk("activeCfg", 8'h02, activeCfg);
    rq(8'h00, REQ_SET_CONFIG, 16'h0003, 16'h0000, 1'b1, 16'h0000);
    rq(8'h00, REQ_SET_CONFIG, 16'h0002, 16'h0000, 1'b0, 16'h0000);
    chk("devState", DEV_CONFIGURED, devState);
    rq(8'h00, REQ_SET_CONFIG, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    chk("devState", DEV_ADDRESS, devState);
    rq(8'h00, REQ_SET_CONFIG, 16'h0002, 16'h0000, 1'b0, 16'h0000);
    rd(REG_STATUS, 32'h0002_0421);
  endtask
  task automatic t_halt();
    rq(8'h02, REQ_SET_FEATURE, FEAT_EP_HALT, 16'h0001, 1'b0, 16'h0000);
    st();
    chk("epStall", 4'h1, epStall);
    rq(8'h82, REQ_GET_STATUS, 16'h0000, 16'h0001, 1'b0, 16'h0001);
    rq(8'h02, REQ_CLR_FEATURE, FEAT_EP_HALT, 16'h0001, 1'b0, 16'h0000);
    st();
    chk("epStall", 4'h0, epStall);
    chk("epSeqRst", 4'h1, epSeqRst);
    chk("epStreamRst", 4'h1, epStreamRst);
    rq(8'h02, REQ_CLR_FEATURE, FEAT_EP_HALT, 16'h0002, 1'b0, 16'h0000);
    st();
    chk("epSeqRst", 4'h2, epSeqRst);
    epHaltCond <= 4'h4;
    st();
    st();
    chk("epStall", 4'h4, epStall);
    rq(8'h02, REQ_CLR_FEATURE, FEAT_EP_HALT, 16'h0003, 1'b0, 16'h0000);
    st();
    chk("epStall", 4'h4, epStall);
    epHaltCond <= 4'h0;
    rq(8'h02, REQ_CLR_FEATURE, FEAT_EP_HALT, 16'h0003, 1'b0, 16'h0000);
    st();
    chk("epStall", 4'h0, epStall);
    rq(8'h02, REQ_SET_FEATURE, FEAT_EP_HALT, 16'h0004, 1'b0, 16'h0000);
    rq(8'h00, REQ_SET_CONFIG, 16'h0002, 16'h0000, 1'b0, 16'h0000);
    st();
    chk("epStall", 4'h0, epStall);
    rq(8'h02, REQ_SET_FEATURE, FEAT_EP_HALT, 16'h0002, 1'b0, 16'h0000);
    rq(8'h01, REQ_SET_IFACE, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    st();
    chk("epStall", 4'h0, epStall);
  endtask
  task automatic t_status();
    rq(8'h80, REQ_GET_STATUS, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    rq(8'h00, REQ_SET_FEATURE, FEAT_LTM, 16'h0000, 1'b0, 16'h0000);
    rq(8'h80, REQ_GET_STATUS, 16'h0000, 16'h0000, 1'b0, 16'h0010);
    rq(8'h00, REQ_CLR_FEATURE, FEAT_LTM, 16'h0000, 1'b0, 16'h0000);
    rq(8'h80, REQ_GET_STATUS, 16'h0000, 16'h0000, 1'b0, 16'h0000);
    rq(8'h81, REQ_GET_STATUS, 16'h0000, 16'h0000, 1'b0, 16'h0001);
    rq(8'h01, REQ_SET_FEATURE, FEAT_FUNC_SUSP, 16'h0200, 1'b0, 16'h0000);
    chk("funcWakeEn", 1, funcWakeEn);
    rq(8'h81, REQ_GET_STATUS, 16'h0000, 16'h0000, 1'b0, 16'h0003);
    rq(8'h81, REQ_GET_STATUS, 16'h0000, 16'h0001, 1'b0, 16'h0000);
    funcRst <= 1'b1;
    st();
    funcRst <= 1'b0;
    chk("funcWakeEn", 0, funcWakeEn);
    rq(8'h81, REQ_GET_STATUS, 16'h0000, 16'h0000, 1'b0, 16'h0001);
    wr(REG_CTRL, 32'h0000_0002);
    rq(8'h81, REQ_GET_STATUS, 16'h0000, 16'h0000, 1'b0, 16'h0000);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic conclude();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // whole run is about a hundred cycles; ceiling leaves ample margin
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    funcRst = 1'b0;
    epHaltCond = 4'h0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_addr();
    t_cfg();
    t_halt();
    t_status();
    conclude();
  end
endmodule
`default_nettype wire
